// ---- bench/dcr_pmm_model.sv ----
/* Power management model: drives the oscillator stops and the slow crystal.
   Assumes hclk at 10 MHz; the crystal runs at 32.768 kHz when fitted. */
`timescale 1ns/1ns
`default_nettype none
module dcr_pmm_model
(
  input  wire logic hclk,
  input  wire logic slow_osc_enable,
  input  wire logic main_clock_good,
  output var logic  stop_main_osc,
  output var logic  stop_slow_osc,
  output var logic  slow_crystal_in
);
  logic fitted = 1'b0;
  int   edges  = 0;
  initial
  begin
    stop_main_osc = 1'b0;
    stop_slow_osc = 1'b0;
    slow_crystal_in = 1'b0;
  end
  // An absent crystal leaves the pin tied low; a disabled one stops low.
  always
  begin
    #15259;
    slow_crystal_in = fitted && slow_osc_enable && !slow_crystal_in;
  end
  always @(posedge slow_crystal_in) edges++;
  task automatic set_stops(input logic m, input logic s);
    @(posedge hclk);
    stop_main_osc <= m;
    stop_slow_osc <= s;
  endtask
  // Counts cycles until the main clock is reported stable.
  task automatic wait_main(output int n);
    n = 0;
    while (main_clock_good !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// ---- bench/dcr_unit_chk.sv ----
/* Checker for dcr_unit: timer, enable and reset relations at the ports.
   Bound to dcr_unit; MAIN_START_CYCLES follows the instance. */
`timescale 1ns/1ns
`default_nettype none
module dcr_unit_chk
#(
  parameter int MAIN_START_CYCLES = 32768
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic stop_main_osc,
  input wire logic stop_slow_osc,
  input wire logic ext_reset_n,
  input wire logic fast_osc_enable,
  input wire logic slow_osc_enable,
  input wire logic main_clock_good,
  input wire logic slow_clk_en,
  input wire logic sys_reset_n
);
  logic [15:0] mcnt, next_mcnt, pcnt, next_pcnt;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles of the current main start-up wait, and cycles since power-up.
  always_comb
  begin
    next_mcnt = (stop_main_osc || main_clock_good) ? 16'h0 : mcnt + 16'h1;
    next_pcnt = (pcnt == 16'hffff) ? pcnt : pcnt + 16'h1;
  end
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      mcnt <= 16'h0;
      pcnt <= 16'h0;
    end
    else
    begin
      mcnt <= next_mcnt;
      pcnt <= next_pcnt;
    end
  property p_main_stop; stop_main_osc ##1 stop_main_osc |-> !main_clock_good && !fast_osc_enable; endproperty
  a_main_stop: assert property (p_main_stop) else $error("main good while stopped");
  property p_main_en; 1'b1 |=> fast_osc_enable == !$past(stop_main_osc); endproperty
  a_main_en: assert property (p_main_en) else $error("fast enable wrong");
  property p_main_early; $rose(main_clock_good) |-> int'(mcnt) >= MAIN_START_CYCLES - 2; endproperty
  a_main_early: assert property (p_main_early) else $error("main good early");
  property p_main_late; int'(mcnt) <= MAIN_START_CYCLES + 4; endproperty
  a_main_late: assert property (p_main_late) else $error("main good late");
  property p_slow_en; 1'b1 |=> slow_osc_enable == !$past(stop_slow_osc); endproperty
  a_slow_en: assert property (p_slow_en) else $error("slow enable wrong");
  property p_slow_pulse; slow_clk_en |=> !slow_clk_en; endproperty
  a_slow_pulse: assert property (p_slow_pulse) else $error("slow enable too wide");
  property p_por_hold; $rose(hresetn) |-> !sys_reset_n [*8]; endproperty
  a_por_hold: assert property (p_por_hold) else $error("reset not held");
  property p_por_rel; $rose(sys_reset_n) |-> int'(pcnt) >= MAIN_START_CYCLES - 2; endproperty
  a_por_rel: assert property (p_por_rel) else $error("reset released early");
  property p_ext; !ext_reset_n [*8] |-> !sys_reset_n; endproperty
  a_ext: assert property (p_ext) else $error("pin reset ignored");
  c_main: cover property ($rose(main_clock_good));
  c_rst: cover property ($rose(sys_reset_n));
  c_slow: cover property ($fell(slow_osc_enable));
endmodule
bind dcr_unit dcr_unit_chk #(.MAIN_START_CYCLES(MAIN_START_CYCLES)) dcr_unit_chk_inst (.hclk, .hresetn,
  .stop_main_osc, .stop_slow_osc, .ext_reset_n, .fast_osc_enable, .slow_osc_enable, .main_clock_good,
  .slow_clk_en, .sys_reset_n);
`default_nettype wire

// ---- bench/testbench.sv ----
/* Self-checking bench for dcr_unit with the power management model.
   Drives AHB-Lite singles; shortens the main start-up count. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dcr_pkg::*;
  localparam int MSC = 64;
  logic        hclk = 1'b0, hresetn = 1'b0, ext_reset_n = 1'b1, hwrite = 1'b0;
  logic [1:0]  htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  wire logic   hready, hresp, fast_osc_enable, slow_osc_enable, main_clock_good, slow_clock_good;
  wire logic   slow_clk_en, sys_reset_n, stop_main_osc, stop_slow_osc, slow_crystal_in;
  wire logic [1:0]  aux_clk_en;
  wire logic [31:0] hrdata;
  wire logic [2:0]  ens = {slow_clk_en, aux_clk_en};
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  dcr_unit #(.MAIN_START_CYCLES(MSC)) dcr_unit_inst (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'b010), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata, .stop_main_osc,
    .stop_slow_osc, .slow_crystal_in, .ext_reset_n, .fast_osc_enable, .slow_osc_enable,
    .main_clock_good, .slow_clock_good, .slow_clk_en, .aux_clk_en, .sys_reset_n);
  dcr_pmm_model dcr_pmm_model_inst (.hclk, .slow_osc_enable, .main_clock_good, .stop_main_osc,
    .stop_slow_osc, .slow_crystal_in);
  always #50 hclk = ~hclk;
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h0, v);
  endtask
  // Cycles between two successive pulses of one clock enable.
  task automatic per(input int s, output int p);
    p = 0;
    @(posedge hclk);
    while (ens[s] !== 1'b1) @(posedge hclk);
    do
    begin
      @(posedge hclk);
      p++;
    end
    while (ens[s] !== 1'b1);
  endtask
  task automatic t_reset();
    int n = 0;
    int p;
    logic [31:0] v;
    while (sys_reset_n !== 1'b1)
    begin
      @(posedge hclk);
      n++;
    end
    chk("por release", 32'h1, 32'(n >= MSC && n <= MSC + 12));
    rd(ADDR_CTRL, v);
    chk("ctrl", 32'h2, v);
    rd(ADDR_PRESCALE, v);
    chk("prescale", 32'hff, v);
    rd(ADDR_AUX, v);
    chk("aux", 32'h0, v);
    rd(8'h10, v);
    chk("unmapped", 32'h0, v);
    chk("hresp", 32'h0, {31'h0, hresp});
    per(2, p);
    chk("slow period", 32'd512, 32'(p));
    per(0, p);
    chk("aux period", 32'd1, 32'(p));
    $display("reset test done");
  endtask
  task automatic t_regs();
    int p;
    logic [31:0] v;
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CTRL, 32'h2);
    rd(ADDR_CTRL, v);
    chk("por flag", 32'h0, v);
    wr(ADDR_PRESCALE, 32'd49);
    per(2, p);
    chk("slow period", 32'd100, 32'(p));
    wr(ADDR_AUX, 32'h3f);
    per(0, p);
    chk("aux one period", 32'd16, 32'(p));
    per(1, p);
    chk("aux two period", 32'd4, 32'(p));
    $display("register test done");
  endtask
  task automatic t_main();
    int n;
    logic [31:0] v;
    dcr_pmm_model_inst.set_stops(1'b1, 1'b0);
    repeat (10) @(posedge hclk);
    chk("main good", 32'h0, {fast_osc_enable, main_clock_good});
    dcr_pmm_model_inst.set_stops(1'b0, 1'b0);
    dcr_pmm_model_inst.wait_main(n);
    chk("main delay", 32'h1, 32'(n >= MSC - 2 && n <= MSC + 6));
    rd(ADDR_STATUS, v);
    chk("status main", 32'h13, v);
    $display("main test done");
  endtask
  task automatic t_sel();
    int p;
    logic [31:0] v;
    wr(ADDR_CTRL, 32'h1);
    repeat (1300) @(posedge hclk);
    rd(ADDR_STATUS, v);
    chk("src no crystal", 32'h0, v[3]);
    per(2, p);
    chk("slow period", 32'd100, 32'(p));
    dcr_pmm_model_inst.fitted = 1'b1;
    repeat (1500) @(posedge hclk);
    rd(ADDR_STATUS, v);
    chk("src crystal", 32'h1, v[3]);
    per(2, p);
    chk("crystal period", 32'h1, 32'(p >= 304 && p <= 307));
    $display("select test done");
  endtask
  task automatic t_slow();
    int e0;
    logic [31:0] v;
    dcr_pmm_model_inst.set_stops(1'b0, 1'b1);
    repeat (1300) @(posedge hclk);
    rd(ADDR_STATUS, v);
    chk("stopped", 32'h0, {slow_osc_enable, v[3]});
    e0 = dcr_pmm_model_inst.edges;
    dcr_pmm_model_inst.set_stops(1'b0, 1'b0);
    while (slow_clock_good !== 1'b0) @(posedge hclk);
    while (slow_clock_good !== 1'b1) @(posedge hclk);
    e0 = dcr_pmm_model_inst.edges - e0;
    chk("slow edges", 32'h1, 32'(e0 >= 62 && e0 <= 66));
    $display("slow test done");
  endtask
  task automatic t_ext();
    logic [31:0] v;
    ext_reset_n <= 1'b0;
    repeat (12) @(posedge hclk);
    chk("pin reset", 32'h0, sys_reset_n);
    repeat (20) @(posedge hclk);
    chk("pin held", 32'h0, sys_reset_n);
    ext_reset_n <= 1'b1;
    repeat (12) @(posedge hclk);
    chk("pin release", 32'h1, sys_reset_n);
    rd(ADDR_CTRL, v);
    chk("por flag", 32'h0, v[1]);
    $display("pin reset test done");
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      conclude();
    end
  end
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_regs();
    t_main();
    t_sel();
    t_slow();
    t_ext();
    conclude();
  end
endmodule
`default_nettype wire

// ---- rtl/dcr_pkg.sv ----
/*
  Constants shared by the dual clock and reset unit: register offsets, field
  positions, reset values, timer presets and timing counts.
  Assumes a 10 MHz system clock and word-aligned AHB-Lite register access.
*/
`default_nettype none
package dcr_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_PRESCALE = 8'h04;
  localparam logic [7:0] ADDR_AUX      = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;

  // Control register fields.
  localparam int CTRL_SEL_BIT = 0;
  localparam int CTRL_POR_BIT = 1;
  localparam logic CTRL_SEL_RESET = 1'b0;
  localparam logic CTRL_POR_RESET = 1'b1;

  // Prescaler registers.
  localparam logic [7:0] PRESCALE_RESET = 8'hff;
  localparam logic [7:0] AUX_RESET      = 8'h00;
  localparam int AUX_W     = 4;
  localparam int AUX1_LSB  = 0;
  localparam int AUX2_LSB  = 4;
  localparam int AUX_COUNT = 2;

  // Status register fields.
  localparam int STAT_MAIN_GOOD_BIT = 0;
  localparam int STAT_SLOW_GOOD_BIT = 1;
  localparam int STAT_TOGGLE_BIT    = 2;
  localparam int STAT_SRC_OSC_BIT   = 3;
  localparam int STAT_POR_DONE_BIT  = 4;

  // Start-up timers.
  localparam int MAIN_TIMER_W = 14;
  localparam logic [MAIN_TIMER_W-1:0] MAIN_TIMER_PRESET = 14'h3fff;
  localparam int SLOW_TIMER_W = 6;
  localparam logic [SLOW_TIMER_W-1:0] SLOW_TIMER_PRESET = 6'h3f;

  // Timing.
  localparam int CLK_HZ                = 10_000_000;
  localparam int MAIN_START_OSC_CYCLES = 32768;
  localparam int MAIN_TIMER_STEP       = MAIN_START_OSC_CYCLES / (int'(MAIN_TIMER_PRESET) + 1);
  localparam int SLOW_OSC_HZ           = 32768;
  localparam int TOGGLE_PERIODS        = 4;
  localparam int TOGGLE_WINDOW_CYCLES  = (CLK_HZ * TOGGLE_PERIODS + SLOW_OSC_HZ - 1) / SLOW_OSC_HZ;
  localparam int TOGGLE_W              = 11;

  typedef enum logic
  {
    DCR_POR_HOLD = 1'b0,
    DCR_POR_DONE = 1'b1
  } dcr_por_t;

endpackage

`default_nettype wire

// ---- rtl/dcr_unit.sv ----
/*
  Dual clock and reset unit: fast and slow oscillator start-up timers,
  slow clock source selection, slow and auxiliary clock enables, power-on
  and external reset merging, and an AHB-Lite register slave.
  Assumes the power management module drives the stop requests on hclk and
  that the slow crystal and external reset pins are asynchronous to hclk.
*/
// The register offsets and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// RQ1: Stop request halts fast oscillator and presets 14-bit timer to all ones.
// RQ2: Stop release restarts oscillator; timer counts down, halts at zero, main good.
// RQ3: Main good follows 32,768 oscillator cycles after restart.
// RQ4: Slow stop request disables slow oscillator, presets 6-bit timer to all ones.
// RQ5: Slow stop release restarts oscillator; timer counts to zero, slow good.
// RQ6: Without slow crystal the slow clock is the divided main clock.
// RQ7: Prescaler is fixed divide-by-two and 8-bit divisor, ratios 2 to 512.
// RQ8: Software keeps the divided slow clock at or below 100 kHz.
// RQ9: Software selects slow source; prescaled main clock chosen after reset.
// RQ10: Selecting the slow oscillator disables the prescaler.
// RQ11: Switch to slow oscillator only while it toggles, else prescaler stays.
// RQ12: Power-on asserts internal reset and presets 14-bit timer to all ones.
// RQ13: Power-on timer counts to zero, then reset releases unless pin low.
// RQ14: Power-up sets a readable power-on flag.
// RQ15: Main clock prescaler yields two additional low-speed clocks.
// RQ16: Slow clock enable is routed out for other modules and power save.
// RQ17: Prescaler divides by twice divisor plus one; divisor resets to maximum.
// RQ18: Software clears the power-on flag only; writing one is ignored.
// RQ19: Auxiliary clocks divide by one plus 4-bit divisor; divisors reset zero.
// RQ20: Low external reset pin asserts internal reset until it returns high.
// RQ21: Main and slow good indications go to the power management module.
module dcr_unit
  import dcr_pkg::*;
#(
  parameter int MAIN_START_CYCLES = MAIN_START_OSC_CYCLES
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              stop_main_osc,
  input  wire logic              stop_slow_osc,
  input  wire logic              slow_crystal_in,
  input  wire logic              ext_reset_n,
  output logic                   fast_osc_enable,
  output logic                   slow_osc_enable,
  output logic                   main_clock_good,
  output logic                   slow_clock_good,
  output logic                   slow_clk_en,
  output logic [AUX_COUNT-1:0]   aux_clk_en,
  output logic                   sys_reset_n
);

  localparam logic [MAIN_TIMER_W-1:0] MAIN_PRESET_P =
    (MAIN_START_CYCLES / MAIN_TIMER_STEP >= int'(MAIN_TIMER_PRESET) + 1) ? MAIN_TIMER_PRESET :
    MAIN_TIMER_W'(MAIN_START_CYCLES / MAIN_TIMER_STEP - 1);
  localparam logic MAIN_STEP_LAST = 1'(MAIN_TIMER_STEP - 1);
  localparam logic [TOGGLE_W-1:0] TOGGLE_LIMIT = TOGGLE_W'(TOGGLE_WINDOW_CYCLES);

  // Pin synchronisers and filtered levels.
  logic [2:0] rst_sync;
  logic [2:0] xtal_sync;
  logic       rst_pin, next_rst_pin;
  logic       xtal_lvl, next_xtal_lvl;
  logic       slow_rise;

  // Timers, sequencer and source selection.
  logic [MAIN_TIMER_W-1:0] main_timer, next_main_timer;
  logic                    main_step, next_main_step;
  logic [SLOW_TIMER_W-1:0] slow_timer, next_slow_timer;
  logic [TOGGLE_W-1:0]     toggle_cnt, next_toggle_cnt;
  logic                    slow_toggling, next_slow_toggling;
  logic                    src_osc, next_src_osc;
  dcr_por_t                por_state, next_por_state;
  logic                    next_main_good, next_slow_good, next_sys_reset_n;

  // Dividers.
  logic [7:0]           pre_cnt, next_pre_cnt;
  logic                 pre_half, next_pre_half, next_slow_clk_en;
  logic [AUX_W-1:0]     aux_cnt [AUX_COUNT], next_aux_cnt [AUX_COUNT];
  logic [AUX_COUNT-1:0] next_aux_clk_en;

  // Registers and bus state.
  logic        slow_select, next_slow_select, por_flag, next_por_flag;
  logic        dp_write, next_dp_write, take;
  logic [7:0]  slow_divisor, next_slow_divisor;
  logic [7:0]  aux_prescale_reg, next_aux_prescale_reg;
  logic [7:0]  dp_addr, next_dp_addr;
  logic [31:0] next_hrdata, rd_mux;

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // A level change counts only once the second and third stages agree.
  always_comb
  begin
    next_rst_pin  = (rst_sync[1] == rst_sync[2]) ? rst_sync[2] : rst_pin;
    next_xtal_lvl = (xtal_sync[1] == xtal_sync[2]) ? xtal_sync[2] : xtal_lvl;
    slow_rise     = next_xtal_lvl & ~xtal_lvl;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rst_sync  <= 3'h0;
      xtal_sync <= 3'h0;
      rst_pin   <= 1'b0;
      xtal_lvl  <= 1'b0;
    end
    else
    begin
      rst_sync  <= {rst_sync[1:0], ext_reset_n};
      xtal_sync <= {xtal_sync[1:0], slow_crystal_in};
      rst_pin   <= next_rst_pin;
      xtal_lvl  <= next_xtal_lvl;
    end
  end

  // Start-up timers, power-on sequencer and slow source selection.
  always_comb
  begin
    next_main_timer = main_timer;
    next_main_step  = main_step;
    if (stop_main_osc)
    begin
      next_main_timer = MAIN_PRESET_P; // [RQ1]
      next_main_step  = 1'b0;
    end
    else if (main_timer != '0)
    begin
      if (main_step == MAIN_STEP_LAST)
      begin
        next_main_step  = 1'b0;
        next_main_timer = main_timer - 1'b1; // [RQ2] [RQ3] [RQ13]
      end
      else
        next_main_step = 1'b1;
    end
    next_main_good = (next_main_timer == '0) && !stop_main_osc; // [RQ2] [RQ21]
    next_slow_timer = slow_timer;
    if (stop_slow_osc)
      next_slow_timer = SLOW_TIMER_PRESET; // [RQ4]
    else if ((slow_timer != '0) && slow_rise)
      next_slow_timer = slow_timer - 1'b1; // [RQ5]
    if (slow_rise)
      next_toggle_cnt = '0;
    else if (toggle_cnt >= TOGGLE_LIMIT)
      next_toggle_cnt = TOGGLE_LIMIT;
    else
      next_toggle_cnt = toggle_cnt + 1'b1;
    next_slow_toggling = (next_toggle_cnt < TOGGLE_LIMIT) && !stop_slow_osc;
    next_src_osc       = slow_select && next_slow_toggling; // [RQ9] [RQ11]
    next_slow_good     = next_src_osc ? ((next_slow_timer == '0) && !stop_slow_osc) // [RQ5] [RQ21]
                                      : next_main_good;
    next_por_state = por_state;
    unique case (por_state)
      DCR_POR_HOLD:
        if (main_timer == '0)
          next_por_state = DCR_POR_DONE; // [RQ13]
      DCR_POR_DONE: next_por_state = DCR_POR_DONE;
    endcase
    next_sys_reset_n = (next_por_state == DCR_POR_DONE) && next_rst_pin; // [RQ13] [RQ20]
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      main_timer      <= MAIN_PRESET_P; // [RQ12]
      main_step       <= 1'b0;
      slow_timer      <= SLOW_TIMER_PRESET;
      toggle_cnt      <= TOGGLE_LIMIT;
      slow_toggling   <= 1'b0;
      src_osc         <= 1'b0;
      por_state       <= DCR_POR_HOLD; // [RQ12]
      main_clock_good <= 1'b0;
      slow_clock_good <= 1'b0;
      sys_reset_n     <= 1'b0; // [RQ12]
      fast_osc_enable <= 1'b0;
      slow_osc_enable <= 1'b0;
    end
    else
    begin
      main_timer      <= next_main_timer;
      main_step       <= next_main_step;
      slow_timer      <= next_slow_timer;
      toggle_cnt      <= next_toggle_cnt;
      slow_toggling   <= next_slow_toggling;
      src_osc         <= next_src_osc;
      por_state       <= next_por_state;
      main_clock_good <= next_main_good;
      slow_clock_good <= next_slow_good;
      sys_reset_n     <= next_sys_reset_n;
      fast_osc_enable <= !stop_main_osc; // [RQ1] [RQ2]
      slow_osc_enable <= !stop_slow_osc; // [RQ4] [RQ5]
    end
  end

  // Slow clock prescaler and auxiliary dividers.
  always_comb
  begin
    next_pre_cnt     = pre_cnt;
    next_pre_half    = pre_half;
    next_slow_clk_en = 1'b0;
    if (src_osc)
    begin
      next_pre_cnt     = 8'h00; // [RQ10]
      next_pre_half    = 1'b0;
      next_slow_clk_en = slow_rise; // [RQ16]
    end
    else if (pre_cnt >= slow_divisor)
    begin
      next_pre_cnt     = 8'h00;
      next_pre_half    = !pre_half;
      next_slow_clk_en = pre_half; // [RQ6] [RQ7] [RQ17] [RQ16]
    end
    else
      next_pre_cnt = pre_cnt + 1'b1;
    for (int i = 0; i < AUX_COUNT; i++)
    begin
      if (aux_cnt[i] >= aux_prescale_reg[i*AUX_W +: AUX_W])
      begin
        next_aux_cnt[i]    = '0;
        next_aux_clk_en[i] = 1'b1; // [RQ15] [RQ19]
      end
      else
      begin
        next_aux_cnt[i]    = aux_cnt[i] + 1'b1;
        next_aux_clk_en[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pre_cnt     <= 8'h00;
      pre_half    <= 1'b0;
      slow_clk_en <= 1'b0;
      aux_clk_en  <= '0;
      aux_cnt     <= '{default: '0};
    end
    else
    begin
      pre_cnt     <= next_pre_cnt;
      pre_half    <= next_pre_half;
      slow_clk_en <= next_slow_clk_en;
      aux_clk_en  <= next_aux_clk_en;
      aux_cnt     <= next_aux_cnt;
    end
  end

  // AHB-Lite slave. Reads use next register values, so a read overlapping a write sees the new data.
  always_comb
  begin
    take                  = hsel && hready && htrans[1];
    next_dp_write         = take && hwrite;
    next_dp_addr          = take ? haddr[7:0] : dp_addr;
    next_slow_select      = slow_select;
    next_por_flag         = por_flag;
    next_slow_divisor     = slow_divisor;
    next_aux_prescale_reg = aux_prescale_reg;
    if (dp_write)
      unique case (dp_addr)
        ADDR_CTRL:
        begin
          next_slow_select = hwdata[CTRL_SEL_BIT]; // [RQ9]
          next_por_flag    = por_flag & hwdata[CTRL_POR_BIT]; // [RQ18]
        end
        ADDR_PRESCALE: next_slow_divisor = hwdata[7:0]; // [RQ17]
        ADDR_AUX:      next_aux_prescale_reg = hwdata[7:0]; // [RQ19]
        default: ;
      endcase
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      ADDR_CTRL:
      begin
        rd_mux[CTRL_SEL_BIT] = next_slow_select;
        rd_mux[CTRL_POR_BIT] = next_por_flag; // [RQ14]
      end
      ADDR_PRESCALE: rd_mux[7:0] = next_slow_divisor;
      ADDR_AUX:      rd_mux[7:0] = next_aux_prescale_reg;
      ADDR_STATUS:
      begin
        rd_mux[STAT_MAIN_GOOD_BIT] = main_clock_good;
        rd_mux[STAT_SLOW_GOOD_BIT] = slow_clock_good;
        rd_mux[STAT_TOGGLE_BIT]    = slow_toggling;
        rd_mux[STAT_SRC_OSC_BIT]   = src_osc;
        rd_mux[STAT_POR_DONE_BIT]  = (por_state == DCR_POR_DONE);
      end
      default: ;
    endcase
    next_hrdata = (take && !hwrite) ? rd_mux : hrdata;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_write         <= 1'b0;
      dp_addr          <= 8'h00;
      hrdata           <= 32'h0000_0000;
      slow_select      <= CTRL_SEL_RESET; // [RQ9]
      por_flag         <= CTRL_POR_RESET; // [RQ14]
      slow_divisor     <= PRESCALE_RESET; // [RQ17]
      aux_prescale_reg <= AUX_RESET; // [RQ19]
    end
    else
    begin
      dp_write         <= next_dp_write;
      dp_addr          <= next_dp_addr;
      hrdata           <= next_hrdata;
      slow_select      <= next_slow_select;
      por_flag         <= next_por_flag;
      slow_divisor     <= next_slow_divisor;
      aux_prescale_reg <= next_aux_prescale_reg;
    end
  end

endmodule

`default_nettype wire
